// File: src/cpwm_pkg.sv
// constants and types for the three-phase complementary pwm generator
//
// Contract
// - three phases, each with positive and antiphase outputs that never overlap
// - a setting produces the complementary waveforms with no dead time
// - an optional extra pin toggles in step with the carrier period
// - peak limit compare is counter a ceiling, reloaded from its buffer
// - phase 1 duty compare sets phase 1 width, reloaded from buffer
// - phase 2 duty compare sets phase 2 width, reloaded from buffer
// - phase 3 duty compare sets phase 3 width, reloaded from buffer
// - duty buffers pass through a hidden temporary before the compare
// - the three temporaries cannot be read or written by software
// - counter a turns down at ceiling and up at dead time value
// - counter b turns down at half cycle and up at zero
// - a 16-bit readable writable dead time register sets dead time
// - a 16-bit half cycle register is counter b turnaround value
// - half cycle register reloads from the half cycle buffer while running
// - buffered values transfer at both counter peak and trough
// - a peak event is raised once per carrier at the ceiling match
// - counters run on the input clock divided by four
// - positive and antiphase outputs are active low
// - counter a starts at dead time value, b at zero, together
package cpwm_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 5;
   // register indices
   localparam logic [4:0] REG_PEAK_CMP   = 5'h00;
   localparam logic [4:0] REG_P1_CMP     = 5'h01;
   localparam logic [4:0] REG_PEAK_BUF   = 5'h02;
   localparam logic [4:0] REG_P1_BUF     = 5'h03;
   localparam logic [4:0] REG_P2_CMP     = 5'h04;
   localparam logic [4:0] REG_P3_CMP     = 5'h05;
   localparam logic [4:0] REG_P2_BUF     = 5'h06;
   localparam logic [4:0] REG_P3_BUF     = 5'h07;
   localparam logic [4:0] REG_CNT_A      = 5'h08;
   localparam logic [4:0] REG_CNT_B      = 5'h09;
   localparam logic [4:0] REG_DEAD       = 5'h0a;
   localparam logic [4:0] REG_HALF       = 5'h0b;
   localparam logic [4:0] REG_HALF_BUF   = 5'h0c;
   localparam logic [4:0] REG_CTRL       = 5'h0d;
   localparam logic [4:0] REG_STATUS     = 5'h0e;
   // control bit positions
   localparam int unsigned CTRL_RUN      = 0;
   localparam int unsigned CTRL_TOGGLE   = 1;
   localparam int unsigned CTRL_NO_DEAD  = 2;
   // status bit positions
   localparam int unsigned STAT_PEAK     = 0;
   localparam int unsigned STAT_DIR_A    = 1;
   localparam int unsigned STAT_DIR_B    = 2;
   localparam int unsigned STAT_TOGGLE   = 3;
   localparam int unsigned STAT_PEND     = 4;
   // reset values
   localparam logic [15:0] RST_ZERO      = 16'h0000;
   localparam logic [15:0] RST_ONES      = 16'hffff;
   // counter clock prescale
   localparam int unsigned PRESCALE      = 4;
   localparam logic [1:0]  PRESCALE_LAST = 2'(PRESCALE - 1);
   // output levels: active low
   localparam logic        LVL_ACTIVE    = 1'b0;
   localparam logic        LVL_IDLE      = 1'b1;

   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } cpwm_bus_type;

   typedef struct packed {
      logic [15:0] cmp;
      logic [15:0] tmp;
      logic [15:0] buf_v;
   } cpwm_duty_type;

   typedef enum logic [1:0] {ST_IDLE, ST_UP, ST_DOWN} cpwm_dir_type;
endpackage : cpwm_pkg

// File: src/cpwm_top.sv
// three-phase complementary pwm generator with register port
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cpwm_top (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [4:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   output logic             peak_event_out,
   output logic             cycle_toggle_out,
   output logic             phase1_pos_out,
   output logic             phase1_neg_out,
   output logic             phase2_pos_out,
   output logic             phase2_neg_out,
   output logic             phase3_pos_out,
   output logic             phase3_neg_out
);
   ////////////////////////////////////////////////////////////////////////
   // registers and next values
   cpwm_pkg::cpwm_bus_type  bus;
   cpwm_pkg::cpwm_duty_type duty_ff [3];
   cpwm_pkg::cpwm_duty_type nxt_duty[3];
   logic [15:0] peak_cmp_ff, nxt_peak_cmp;
   logic [15:0] peak_buf_ff, nxt_peak_buf;
   logic [15:0] dead_ff,     nxt_dead;
   logic [15:0] half_ff,     nxt_half;
   logic [15:0] half_buf_ff, nxt_half_buf;
   logic [15:0] cnt_a_ff,    nxt_cnt_a;
   logic [15:0] cnt_b_ff,    nxt_cnt_b;
   logic        dir_a_ff,    nxt_dir_a;     // 1 = counting down
   logic        dir_b_ff,    nxt_dir_b;
   logic [2:0]  ctrl_ff,     nxt_ctrl;
   logic        pend_ff,     nxt_pend;      // phase 3 buffer written
   logic        peak_flag_ff, nxt_peak_flag;
   logic [1:0]  pre_ff,      nxt_pre;
   logic        tog_ff,      nxt_tog;
   logic        peak_ev_ff,  nxt_peak_ev;
   logic [15:0] rdata_ff,    nxt_rdata;
   logic [5:0]  pins_ff,     nxt_pins;
   logic        tick;
   logic        at_peak;
   logic        at_trough;

   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   // positive output active when both counters sit below duty (counter b alone without dead time), per phase
   function automatic logic [1:0] phase_lvl(input logic [15:0] cmp,
                                            input logic [15:0] ca,
                                            input logic [15:0] cb,
                                            input logic [15:0] dt,
                                            input logic        nodead);
      logic pos_on;
      logic neg_on;
      pos_on = 1'b0;
      neg_on = 1'b0;
      // positive side on while both counters sit below the duty point;
      // antiphase side on while both sit at or above it.
      // counter a leads counter b by dt, so the gap is one dead time
      if (nodead) begin
         pos_on = (cb < cmp);
         neg_on = !(cb < cmp);
      end else begin
         pos_on = (ca < cmp) && (cb < cmp) && (cmp > dt);
         neg_on = (ca >= cmp) && (cb >= cmp);
      end
      // never both active: antiphase yields to positive
      if (pos_on) begin
         neg_on = 1'b0;
      end
      phase_lvl = {pos_on ? cpwm_pkg::LVL_ACTIVE : cpwm_pkg::LVL_IDLE,
                   neg_on ? cpwm_pkg::LVL_ACTIVE : cpwm_pkg::LVL_IDLE};
   endfunction : phase_lvl

   ////////////////////////////////////////////////////////////////////////
   // prescaler and turnaround detection
   always_comb begin
      nxt_pre = ctrl_ff[cpwm_pkg::CTRL_RUN] ?
                2'(pre_ff + 2'h1) : 2'h0;
      tick      = ctrl_ff[cpwm_pkg::CTRL_RUN] &&
                  (pre_ff == cpwm_pkg::PRESCALE_LAST);
      at_peak   = tick && !dir_a_ff && (cnt_a_ff == peak_cmp_ff);
      at_trough = tick && dir_b_ff && (cnt_b_ff == 16'h0000);
   end

   ////////////////////////////////////////////////////////////////////////
   // counters, buffer transfers and register writes
   always_comb begin
      nxt_cnt_a     = cnt_a_ff;
      nxt_cnt_b     = cnt_b_ff;
      nxt_dir_a     = dir_a_ff;
      nxt_dir_b     = dir_b_ff;
      nxt_peak_cmp  = peak_cmp_ff;
      nxt_peak_buf  = peak_buf_ff;
      nxt_dead      = dead_ff;
      nxt_half      = half_ff;
      nxt_half_buf  = half_buf_ff;
      nxt_ctrl      = ctrl_ff;
      nxt_pend      = pend_ff;
      nxt_peak_flag = peak_flag_ff;
      nxt_tog       = tog_ff;
      nxt_duty      = duty_ff;
      nxt_peak_ev   = at_peak;
      // counter a bounces between dead time and ceiling
      if (tick) begin
         if (!dir_a_ff) begin
            if (cnt_a_ff >= peak_cmp_ff) begin
               nxt_dir_a = 1'b1;
               nxt_cnt_a = 16'(cnt_a_ff - 16'h0001);
            end else begin
               nxt_cnt_a = 16'(cnt_a_ff + 16'h0001);
            end
         end else begin
            if (cnt_a_ff <= dead_ff) begin
               nxt_dir_a = 1'b0;
               nxt_cnt_a = 16'(cnt_a_ff + 16'h0001);
            end else begin
               nxt_cnt_a = 16'(cnt_a_ff - 16'h0001);
            end
         end
         // counter b bounces between zero and half cycle
         if (!dir_b_ff) begin
            if (cnt_b_ff >= half_ff) begin
               nxt_dir_b = 1'b1;
               nxt_cnt_b = 16'(cnt_b_ff - 16'h0001);
            end else begin
               nxt_cnt_b = 16'(cnt_b_ff + 16'h0001);
            end
         end else begin
            if (cnt_b_ff == 16'h0000) begin
               nxt_dir_b = 1'b0;
               nxt_cnt_b = 16'h0001;
            end else begin
               nxt_cnt_b = 16'(cnt_b_ff - 16'h0001);
            end
         end
      end
      // toggle pin flips at each peak, if enabled
      if (at_peak && ctrl_ff[cpwm_pkg::CTRL_TOGGLE]) begin
         nxt_tog = !tog_ff;
      end
      // peak and trough: temporaries into compares, limits from buffers
      if (at_peak || at_trough) begin
         for (int i = 0; i < 3; i++) begin
            nxt_duty[i].cmp = duty_ff[i].tmp;
         end
         nxt_peak_cmp = peak_buf_ff;
         nxt_half     = half_buf_ff;
      end
      // buffers reach temporaries once phase 3 buffer was written
      if (pend_ff) begin
         for (int i = 0; i < 3; i++) begin
            nxt_duty[i].tmp = duty_ff[i].buf_v;
         end
         nxt_pend = 1'b0;
      end
      // sticky peak flag; set wins over a software clear
      if (bus.wr && bus.addr == cpwm_pkg::REG_STATUS &&
          bus.wdata[cpwm_pkg::STAT_PEAK]) begin
         nxt_peak_flag = 1'b0;
      end
      if (at_peak) begin
         nxt_peak_flag = 1'b1;
      end
      // register writes; temporaries have no address
      if (bus.wr) begin
         case (bus.addr)
            cpwm_pkg::REG_PEAK_CMP: nxt_peak_cmp = bus.wdata;
            cpwm_pkg::REG_P1_CMP:   nxt_duty[0].cmp = bus.wdata;
            cpwm_pkg::REG_P2_CMP:   nxt_duty[1].cmp = bus.wdata;
            cpwm_pkg::REG_P3_CMP:   nxt_duty[2].cmp = bus.wdata;
            cpwm_pkg::REG_PEAK_BUF: nxt_peak_buf = bus.wdata;
            cpwm_pkg::REG_P1_BUF:   nxt_duty[0].buf_v = bus.wdata;
            cpwm_pkg::REG_P2_BUF:   nxt_duty[1].buf_v = bus.wdata;
            cpwm_pkg::REG_P3_BUF: begin
               nxt_duty[2].buf_v = bus.wdata;
               nxt_pend = 1'b1;
            end
            cpwm_pkg::REG_CNT_A:    nxt_cnt_a = bus.wdata;
            cpwm_pkg::REG_CNT_B:    nxt_cnt_b = bus.wdata;
            cpwm_pkg::REG_DEAD:     nxt_dead = bus.wdata;
            cpwm_pkg::REG_HALF:     nxt_half = bus.wdata;
            cpwm_pkg::REG_HALF_BUF: nxt_half_buf = bus.wdata;
            cpwm_pkg::REG_CTRL: begin
               nxt_ctrl = bus.wdata[2:0];
               // start from run edge: a at dead time, b at zero
               if (bus.wdata[cpwm_pkg::CTRL_RUN] &&
                   !ctrl_ff[cpwm_pkg::CTRL_RUN]) begin
                  nxt_cnt_a = dead_ff;
                  nxt_cnt_b = 16'h0000;
                  nxt_dir_a = 1'b0;
                  nxt_dir_b = 1'b0;
                  for (int i = 0; i < 3; i++) begin
                     nxt_duty[i].tmp = duty_ff[i].cmp;
                  end
               end
               if (!bus.wdata[cpwm_pkg::CTRL_TOGGLE]) begin
                  nxt_tog = 1'b0;           // low whenever disabled
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; data stands the cycle after the strobe only
   always_comb begin
      nxt_rdata = 16'h0000;
      if (bus.rd) begin
         case (bus.addr)
            cpwm_pkg::REG_PEAK_CMP: nxt_rdata = peak_cmp_ff;
            cpwm_pkg::REG_P1_CMP:   nxt_rdata = duty_ff[0].cmp;
            cpwm_pkg::REG_P2_CMP:   nxt_rdata = duty_ff[1].cmp;
            cpwm_pkg::REG_P3_CMP:   nxt_rdata = duty_ff[2].cmp;
            cpwm_pkg::REG_PEAK_BUF: nxt_rdata = peak_buf_ff;
            cpwm_pkg::REG_P1_BUF:   nxt_rdata = duty_ff[0].buf_v;
            cpwm_pkg::REG_P2_BUF:   nxt_rdata = duty_ff[1].buf_v;
            cpwm_pkg::REG_P3_BUF:   nxt_rdata = duty_ff[2].buf_v;
            cpwm_pkg::REG_CNT_A:    nxt_rdata = cnt_a_ff;
            cpwm_pkg::REG_CNT_B:    nxt_rdata = cnt_b_ff;
            cpwm_pkg::REG_DEAD:     nxt_rdata = dead_ff;
            cpwm_pkg::REG_HALF:     nxt_rdata = half_ff;
            cpwm_pkg::REG_HALF_BUF: nxt_rdata = half_buf_ff;
            cpwm_pkg::REG_CTRL:     nxt_rdata = {13'h0000, ctrl_ff};
            cpwm_pkg::REG_STATUS:
               nxt_rdata = {11'h000, pend_ff, tog_ff, dir_b_ff,
                            dir_a_ff, peak_flag_ff};
            default:                nxt_rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output pins; idle (high) while stopped
   always_comb begin
      nxt_pins = {6{cpwm_pkg::LVL_IDLE}};
      if (ctrl_ff[cpwm_pkg::CTRL_RUN]) begin
         for (int i = 0; i < 3; i++) begin
            nxt_pins[2*i +: 2] = phase_lvl(duty_ff[i].cmp, cnt_a_ff,
                                 cnt_b_ff, dead_ff,
                                 ctrl_ff[cpwm_pkg::CTRL_NO_DEAD]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 3; i++) begin
            duty_ff[i] <= '{cmp: cpwm_pkg::RST_ZERO,
                            tmp: cpwm_pkg::RST_ZERO,
                            buf_v: cpwm_pkg::RST_ZERO};
         end
         peak_cmp_ff  <= cpwm_pkg::RST_ONES;
         peak_buf_ff  <= cpwm_pkg::RST_ONES;
         dead_ff      <= cpwm_pkg::RST_ONES;
         half_ff      <= cpwm_pkg::RST_ONES;
         half_buf_ff  <= cpwm_pkg::RST_ONES;
         cnt_a_ff     <= cpwm_pkg::RST_ZERO;
         cnt_b_ff     <= cpwm_pkg::RST_ZERO;
         dir_a_ff     <= 1'b0;
         dir_b_ff     <= 1'b0;
         ctrl_ff      <= 3'h0;
         pend_ff      <= 1'b0;
         peak_flag_ff <= 1'b0;
         pre_ff       <= 2'h0;
         tog_ff       <= 1'b0;
         peak_ev_ff   <= 1'b0;
         rdata_ff     <= 16'h0000;
         pins_ff      <= 6'h3f;
      end else begin
         duty_ff      <= nxt_duty;
         peak_cmp_ff  <= nxt_peak_cmp;
         peak_buf_ff  <= nxt_peak_buf;
         dead_ff      <= nxt_dead;
         half_ff      <= nxt_half;
         half_buf_ff  <= nxt_half_buf;
         cnt_a_ff     <= nxt_cnt_a;
         cnt_b_ff     <= nxt_cnt_b;
         dir_a_ff     <= nxt_dir_a;
         dir_b_ff     <= nxt_dir_b;
         ctrl_ff      <= nxt_ctrl;
         pend_ff      <= nxt_pend;
         peak_flag_ff <= nxt_peak_flag;
         pre_ff       <= nxt_pre;
         tog_ff       <= nxt_tog;
         peak_ev_ff   <= nxt_peak_ev;
         rdata_ff     <= nxt_rdata;
         pins_ff      <= nxt_pins;
      end
   end

   assign rdata_out        = rdata_ff;
   assign peak_event_out   = peak_ev_ff;
   assign cycle_toggle_out = tog_ff;
   assign phase1_pos_out   = pins_ff[1];
   assign phase1_neg_out   = pins_ff[0];
   assign phase2_pos_out   = pins_ff[3];
   assign phase2_neg_out   = pins_ff[2];
   assign phase3_pos_out   = pins_ff[5];
   assign phase3_neg_out   = pins_ff[4];
endmodule : cpwm_top

// File: verif/cpwm_chk.sv
// concurrent assertions watching the pwm generator ports
`timescale 1ns/1ps
module cpwm_chk (
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic [4:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic        peak_event_out,
   input wire logic        cycle_toggle_out,
   input wire logic        phase1_pos_out,
   input wire logic        phase1_neg_out,
   input wire logic        phase2_pos_out,
   input wire logic        phase2_neg_out,
   input wire logic        phase3_pos_out,
   input wire logic        phase3_neg_out
);
   logic        run_ff, nxt_run, tog_ff, nxt_tog, nd_ff, nxt_nd;
   logic [15:0] dead_ff, nxt_dead;
   logic [17:0] gap_ff, nxt_gap;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   ////////////////////////////////////////////////////////////////////////
   // shadow of control bits and dead time, snooped from register writes
   always_comb begin
      nxt_run  = run_ff;
      nxt_tog  = tog_ff;
      nxt_nd   = nd_ff;
      nxt_dead = dead_ff;
      if (wr_in && addr_in == cpwm_pkg::REG_CTRL) begin
         nxt_run = wdata_in[cpwm_pkg::CTRL_RUN];
         nxt_tog = wdata_in[cpwm_pkg::CTRL_TOGGLE];
         nxt_nd  = wdata_in[cpwm_pkg::CTRL_NO_DEAD];
      end
      if (wr_in && addr_in == cpwm_pkg::REG_DEAD) begin
         nxt_dead = wdata_in;
      end
      // idle cycles of phase 1; wraps only after a very long stop
      nxt_gap = (phase1_pos_out && phase1_neg_out) ? gap_ff + 18'h00001
                                                   : 18'h00000;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_ff  <= 1'b0;
         tog_ff  <= 1'b0;
         nd_ff   <= 1'b0;
         dead_ff <= cpwm_pkg::RST_ONES;
         gap_ff  <= 18'h00000;
      end else begin
         run_ff  <= nxt_run;
         tog_ff  <= nxt_tog;
         nd_ff   <= nxt_nd;
         dead_ff <= nxt_dead;
         gap_ff  <= nxt_gap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // legs of one phase never on together, a short across the bridge
   overlap_guard_a: assert property (
      (phase1_pos_out || phase1_neg_out) && (phase2_pos_out || phase2_neg_out)
      && (phase3_pos_out || phase3_neg_out))
      else $error("both legs of a phase active");
   no_dead_pairs_a: assert property (
      nd_ff && $past(nd_ff) && run_ff && $past(run_ff, 2) |->
      (phase1_pos_out != phase1_neg_out) && (phase2_pos_out != phase2_neg_out)
      && (phase3_pos_out != phase3_neg_out))
      else $error("legs not complementary without dead time");
   toggle_at_peak_a: assert property (
      $rose(cycle_toggle_out) |-> peak_event_out || $past(peak_event_out))
      else $error("toggle pin rose away from a peak");
   toggle_off_a: assert property (
      !tog_ff && !$past(tog_ff) |-> !cycle_toggle_out)
      else $error("toggle pin high while disabled");
   peak_spacing_a: assert property (
      peak_event_out |=> !peak_event_out [*7])
      else $error("peak events too close");
   peak_needs_run_a: assert property (
      peak_event_out |-> $past(run_ff))
      else $error("peak event while stopped");
   idle_pins_a: assert property (
      !run_ff && !$past(run_ff) |->
      {phase1_pos_out, phase1_neg_out, phase2_pos_out, phase2_neg_out,
       phase3_pos_out, phase3_neg_out} == 6'h3f)
      else $error("pwm pin active while stopped");
   // tolerance of two cycles covers the pin register and prescale phase
   dead_gap_a: assert property (
      run_ff && !nd_ff && !$past(nd_ff) && $fell(phase1_neg_out) |->
      int'(gap_ff) + 2 >= 4 * int'(dead_ff))
      else $error("antiphase turned on before dead time elapsed");
   rdata_quiet_a: assert property (
      !$past(rd_in) || $past(addr_in) > cpwm_pkg::REG_STATUS |->
      rdata_out == 16'h0000)
      else $error("read data outside a valid read");
   dead_readback_a: assert property (
      $past(rd_in) && $past(addr_in) == cpwm_pkg::REG_DEAD |->
      rdata_out == dead_ff)
      else $error("dead time readback differs from last write");
endmodule : cpwm_chk

// File: verif/cpwm_gate_model.sv
// gate driver model: counts on-cycles per upper leg and shoot-through
`timescale 1ns/1ps
module cpwm_gate_model (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [2:0]       pos_n_in,
   input  wire logic [2:0]       neg_n_in,
   output logic      [2:0][19:0] on_cnt_out,
   output logic      [19:0]      shoot_cnt_out
);
   // a low level switches a gate on; both legs on would short the bridge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         on_cnt_out    <= '0;
         shoot_cnt_out <= 20'h00000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (pos_n_in[i] == 1'b0) begin
               on_cnt_out[i] <= on_cnt_out[i] + 20'h1;
            end
         end
         if ((pos_n_in | neg_n_in) != 3'h7) begin
            shoot_cnt_out <= shoot_cnt_out + 20'h1;
         end
      end
   end
endmodule : cpwm_gate_model

// File: verif/tb_complementary_pwm_three_phase.sv
// self-checking bench for the complementary pwm generator
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module tb_complementary_pwm_three_phase;
   logic             clk_in, reset_n_in, wr_in, rd_in, tg;
   logic [4:0]       addr_in;
   logic [15:0]      wdata_in, rdata_out, rv;
   logic             peak_event_out, cycle_toggle_out;
   logic [2:0]       pos_n, neg_n;
   logic [2:0][19:0] on_cnt, c0;
   logic [19:0]      shoot_cnt;
   int               fail_count = 0;
   int               num_checks = 0;
   int               n;
   // reset image and the run set-up: dead 2, peak 10, half 8
   logic [4:0]  ra [9] = '{cpwm_pkg::REG_PEAK_CMP, cpwm_pkg::REG_P1_CMP,
      cpwm_pkg::REG_PEAK_BUF, cpwm_pkg::REG_DEAD, cpwm_pkg::REG_HALF,
      cpwm_pkg::REG_HALF_BUF, cpwm_pkg::REG_CNT_A, 5'h0f, 5'h1f};
   logic [15:0] rx [9] = '{16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'h0000, 16'h0000, 16'h0000};
   logic [4:0]  ca [8] = '{cpwm_pkg::REG_DEAD, cpwm_pkg::REG_PEAK_BUF,
      cpwm_pkg::REG_HALF_BUF, cpwm_pkg::REG_PEAK_CMP, cpwm_pkg::REG_HALF,
      cpwm_pkg::REG_P1_CMP, cpwm_pkg::REG_P2_CMP, cpwm_pkg::REG_P3_CMP};
   logic [15:0] cd [8] = '{16'h0002, 16'h000a, 16'h0008, 16'h000a, 16'h0008,
      16'h0000, 16'hffff, 16'h0006};

   cpwm_top u_cpwm_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .peak_event_out(peak_event_out),
      .cycle_toggle_out(cycle_toggle_out),
      .phase1_pos_out(pos_n[0]), .phase1_neg_out(neg_n[0]),
      .phase2_pos_out(pos_n[1]), .phase2_neg_out(neg_n[1]),
      .phase3_pos_out(pos_n[2]), .phase3_neg_out(neg_n[2]));
   cpwm_gate_model u_cpwm_gate_model (.clk_in(clk_in), .rst_n_in(reset_n_in),
      .pos_n_in(pos_n), .neg_n_in(neg_n), .on_cnt_out(on_cnt),
      .shoot_cnt_out(shoot_cnt));

   ////////////////////////////////////////////////////////////////////////
   // register port cycles: strobes launched just after a rising edge
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : wr
   // data stands only in the cycle after the strobe, so take it mid-cycle
   task rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      @(negedge clk_in);
      d = rdata_out;
   endtask : rd
   task cmp_rd(input logic [4:0] a, input logic [15:0] x);
      rd(a, rv);
      `CHK(rv, x)
   endtask : cmp_rd
   // cycles until the next peak pulse, bounded so a dead counter is seen
   task peak(output int cyc);
      cyc = 0;
      do begin
         @(negedge clk_in);
         cyc++;
      end while (peak_event_out !== 1'b1 && cyc < 3000);
      if (cyc >= 3000) begin
         fail_count++;
         $display("BAD %0t no peak event", $time);
      end
   endtask : peak
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // a healthy run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end

   initial begin
      addr_in = 5'h00;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      reset_n_in = 1'b0;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      `CHK({pos_n, neg_n, cycle_toggle_out}, 7'h7e)
      for (int i = 0; i < 9; i++) cmp_rd(ra[i], rx[i]);
      for (int i = 0; i < 8; i++) wr(ca[i], cd[i]);
      for (int i = 0; i < 8; i++) cmp_rd(ca[i], cd[i]);
      wr(5'h10, 16'h1234);
      cmp_rd(5'h10, 16'h0000);
      wr(cpwm_pkg::REG_CTRL, 16'h0003);
      rd(cpwm_pkg::REG_CNT_A, rv);
      `CHK((rv - 16'h0002) <= 16'h0001, 1'b1)
      rd(cpwm_pkg::REG_CNT_B, rv);
      `CHK(rv <= 16'h0002, 1'b1)
      // one whole carrier: 2 x (10 - 2) steps of 4 clocks
      peak(n);
      tg = cycle_toggle_out;
      c0 = on_cnt;
      peak(n);
      `CHK(n, 64)
      `CHK(cycle_toggle_out, ~tg)
      `CHK(on_cnt[0] - c0[0], 20'h00000)
      `CHK(on_cnt[1] - c0[1], 20'h00040)
      `CHK(on_cnt[2] - c0[2], 20'h0001c)
      rd(cpwm_pkg::REG_STATUS, rv);
      `CHK(rv[cpwm_pkg::STAT_PEAK], 1'b1)
      wr(cpwm_pkg::REG_STATUS, 16'h0001);
      rd(cpwm_pkg::REG_STATUS, rv);
      `CHK(rv[cpwm_pkg::STAT_PEAK], 1'b0)
      // duty update released by the phase 3 write, landing at the trough
      peak(n);
      wr(cpwm_pkg::REG_P1_BUF, 16'h0005);
      wr(cpwm_pkg::REG_P2_BUF, 16'h0000);
      wr(cpwm_pkg::REG_P3_BUF, 16'h0006);
      cmp_rd(cpwm_pkg::REG_P3_BUF, 16'h0006);
      cmp_rd(cpwm_pkg::REG_P1_CMP, 16'h0000);
      repeat (30) @(posedge clk_in);
      cmp_rd(cpwm_pkg::REG_P1_CMP, 16'h0005);
      cmp_rd(cpwm_pkg::REG_P2_CMP, 16'h0000);
      cmp_rd(cpwm_pkg::REG_P3_CMP, 16'h0006);
      // longer carrier through the buffers: 2 x (14 - 2) x 4 clocks
      wr(cpwm_pkg::REG_PEAK_BUF, 16'h000e);
      wr(cpwm_pkg::REG_HALF_BUF, 16'h000c);
      peak(n);
      peak(n);
      c0 = on_cnt;
      peak(n);
      `CHK(n, 96)
      `CHK(on_cnt[0] - c0[0], 20'h00014)
      `CHK(on_cnt[1] - c0[1], 20'h00000)
      cmp_rd(cpwm_pkg::REG_HALF, 16'h000c);
      cmp_rd(cpwm_pkg::REG_PEAK_CMP, 16'h000e);
      // without dead time phase 1 follows counter b alone
      wr(cpwm_pkg::REG_CTRL, 16'h0007);
      peak(n);
      c0 = on_cnt;
      peak(n);
      `CHK(on_cnt[0] - c0[0], 20'h00024)
      wr(cpwm_pkg::REG_CTRL, 16'h0001);
      repeat (3) @(negedge clk_in);
      `CHK(cycle_toggle_out, 1'b0)
      wr(cpwm_pkg::REG_CTRL, 16'h0000);
      repeat (3) @(negedge clk_in);
      `CHK({pos_n, neg_n}, 6'h3f)
      `CHK(shoot_cnt, 20'h00000)
      conclude();
   end
endmodule : tb_complementary_pwm_three_phase

bind cpwm_top cpwm_chk u_cpwm_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .peak_event_out(peak_event_out),
   .cycle_toggle_out(cycle_toggle_out),
   .phase1_pos_out(phase1_pos_out), .phase1_neg_out(phase1_neg_out),
   .phase2_pos_out(phase2_pos_out), .phase2_neg_out(phase2_neg_out),
   .phase3_pos_out(phase3_pos_out), .phase3_neg_out(phase3_neg_out));
